// File: rtl/dci_pkg.sv
/*
 * Constants and carrier types for the dual-core interrupt router.
 * Assumes a single 40 MHz clock domain and an 8-bit byte address on the register port.
 */
package dci_pkg;
   // ==========================================================
   // Sizes
   localparam int N_SLOT = 64;
   localparam int N_PERIPH = 54;
   localparam int N_GPIO = 33;
   localparam int N_EVT = 128;
   localparam int N_SEL = 12;
   localparam int N_LINE = 15;
   localparam int N_DBL = 5;
   localparam int N_CMB = 4;
   localparam int CFG_W = 4;
   localparam int CFG_PRIO_W = 3;
   localparam int CFG_FIQ_BIT = 3;
   localparam int EVT_W = 7;
   localparam int SEL_FIELD_W = 8;
   // ==========================================================
   // Fixed placement of sources in the control-processor slots
   localparam int SLOT_GPIO_PIN = 54;
   localparam int N_GPIO_SLOT = 4;
   localparam int SLOT_GPIO_GRP = 58;
   localparam int SLOT_DBL = 59;
   localparam int N_ACTIVE = 60;
   // ==========================================================
   // Fixed placement of system events on the signal-processor side
   localparam int EVT_COMB = 0;
   localparam int EVT_A2D = 16;
   localparam int EVT_PERIPH = 32;
   localparam int EVT_GPIO = 86;
   localparam int EVT_GPIO_GRP = 119;
   localparam int N_A2D = 4;
   localparam int DBL_D2A = 4;
   // ==========================================================
   // Signal-processor line positions
   localparam int LINE_RST = 0;
   localparam int LINE_NMI = 1;
   localparam int LINE_EXC = 2;
   localparam int LINE_SEL = 3;
   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] ADR_EN_LO = 8'h00;
   localparam logic [7:0] ADR_EN_HI = 8'h04;
   localparam logic [7:0] ADR_CFG0 = 8'h08;
   localparam logic [7:0] ADR_STAT = 8'h28;
   localparam logic [7:0] ADR_PEND_LO = 8'h2C;
   localparam logic [7:0] ADR_PEND_HI = 8'h30;
   localparam logic [7:0] ADR_SEL0 = 8'h34;
   localparam logic [7:0] ADR_CMB0 = 8'h40;
   localparam logic [7:0] ADR_EXC0 = 8'h50;
   localparam logic [7:0] ADR_DMASK = 8'h60;
   localparam logic [7:0] ADR_DLINE = 8'h64;
   localparam logic [7:0] ADR_DCTL = 8'h68;
   localparam logic [7:0] ADR_POL_LO = 8'h6C;
   localparam logic [7:0] ADR_POL_HI = 8'h70;
   localparam logic [7:0] ADR_DBL_STAT = 8'h74;
   localparam logic [7:0] ADR_DBL_CLR = 8'h78;
   localparam logic [7:0] ADR_DBL_EN = 8'h7C;
   localparam logic [7:0] ADR_DBL_RING = 8'h80;
   // ==========================================================
   // Reset values
   localparam logic RST_DCTL = 1'b1;
   localparam logic [N_DBL-1:0] RST_DBL_EN = 5'h00;
   // ==========================================================
   // Carrier of one arbitration result
   typedef struct packed {
      logic valid;
      logic [5:0] idx;
   } dci_win_s;
endpackage

// File: rtl/dci_gpio_edge.sv
/*
 * Pin event detector: synchronises general-purpose pins and reports the active edge per pin and as a group.
 * Assumes pins are asynchronous to CLK and polarity bits come from logic on CLK.
 */
`timescale 1ns/1ps
module dci_gpio_edge #(
   parameter int WIDTH = 33
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] pin,
   input wire logic [WIDTH-1:0] pol,
   output logic [WIDTH-1:0] evt,
   output logic grp
);
   logic [WIDTH-1:0] s1, s2, prev;
   logic [WIDTH-1:0] next_evt;
   logic next_grp;

   // ==========================================================
   // Edge decision
   // polarity picks edge: a set bit selects the falling edge, a clear one the rising edge.
   always_comb begin
      next_evt = pol & prev & ~s2 | ~pol & ~prev & s2;
      // group event. Any pin event also raises the shared group line.
      next_grp = |next_evt;
   end

   // Only s2 reads s1; the edge logic looks at s2 and prev.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1 <= '0;
         s2 <= '0;
         prev <= '0;
         evt <= '0;
         grp <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         prev <= s2;
         evt <= next_evt;
         grp <= next_grp;
      end
   end
endmodule // dci_gpio_edge

// File: rtl/dci_prio_arb.sv
/*
 * Priority arbiter over all control-processor slots; level 0 is most urgent, ties go to the lowest slot.
 * Assumes requests are already gated by enable and steering.
 */
`timescale 1ns/1ps
module dci_prio_arb (
   input wire logic [dci_pkg::N_SLOT-1:0] req,
   input wire logic [dci_pkg::N_SLOT*dci_pkg::CFG_W-1:0] cfg,
   output dci_pkg::dci_win_s win
);
   import dci_pkg::*;

   // ==========================================================
   // Linear search; one slot per step keeps the tie rule obvious.
   // priority arbitration. Strictly lower level wins, so the first of equals holds.
   always_comb begin
      logic [CFG_PRIO_W-1:0] best;
      best = '1;
      win = '0;
      for (int i = 0; i < N_SLOT; i++) begin
         if (req[i] && (!win.valid || cfg[i*CFG_W +: CFG_PRIO_W] < best)) begin
            win.valid = 1'b1;
            win.idx = 6'(i);
            best = cfg[i*CFG_W +: CFG_PRIO_W];
         end
      end
   end
endmodule // dci_prio_arb

// File: rtl/dci_top.sv
/*
 * Dual-core interrupt router: control-processor controller with IRQ/FIQ and eight levels,
 * signal-processor event selector with combiners, pin events and inter-core doorbells.
 * Assumes peripheral lines and the doorbell strobe are on CLK; pins and NMI are asynchronous.
 */
`timescale 1ns/1ps
module dci_top (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [dci_pkg::N_PERIPH-1:0] PERIPH_IRQ,
   input wire logic [dci_pkg::N_GPIO-1:0] GPIO_PIN,
   input wire logic NMI_PIN,
   input wire logic DSP_RING,
   output logic ARM_IRQ,
   output logic [5:0] ARM_IRQ_NUM,
   output logic ARM_FIQ,
   output logic [5:0] ARM_FIQ_NUM,
   output logic [dci_pkg::N_LINE-1:0] DSP_INT,
   output logic DBL_INT
);
   import dci_pkg::*;

   // ==========================================================
   // Configuration and state registers
   logic [N_SLOT-1:0] en, next_en, pend, next_pend, src;
   logic [N_SLOT*CFG_W-1:0] cfg, next_cfg;
   logic [N_SEL-1:0][EVT_W-1:0] sel, next_sel;
   logic [N_CMB-1:0][31:0] cmb_mask, next_cmb_mask;
   logic [N_EVT-1:0] exc_mask, next_exc_mask, evt, evt_nc;
   logic [N_SEL-1:0] dmask, next_dmask;
   logic dctl, next_dctl;
   logic [N_GPIO-1:0] pol, next_pol, pin_evt;
   logic [N_DBL-1:0] dbl_stat, next_dbl_stat, dbl_en, next_dbl_en, dbl_set, dbl_clr;
   logic [N_SLOT-1:0] steer_fiq, req_irq, req_fiq;
   logic [N_CMB-1:0] cmb, next_cmb;
   logic [N_LINE-1:0] next_line;
   logic [31:0] next_rdata;
   logic grp_evt, nmi_s1, nmi_s2, next_dbl_int;
   dci_win_s irq_win, fiq_win;

   // ==========================================================
   // Pin events and slot assembly
   dci_gpio_edge #(.WIDTH(N_GPIO)) u_gpio (
      .clk(CLK),
      .nrst(NRST),
      .pin(GPIO_PIN),
      .pol(pol),
      .evt(pin_evt),
      .grp(grp_evt)
   );

   // 64 slots. Slots 0..59 carry live sources, the rest stay zero.
   always_comb begin
      // spare slots tied. Slots 60..63 never see a request.
      src = '0;
      // sixty live slots. Peripherals, four pins, pin group, doorbell.
      src[N_PERIPH-1:0] = PERIPH_IRQ;
      // per-pin routing. The first pins also reach the control side one by one.
      src[SLOT_GPIO_PIN +: N_GPIO_SLOT] = pin_evt[N_GPIO_SLOT-1:0];
      src[SLOT_GPIO_GRP] = grp_evt;
      // signal to control. The doorbell summary is a normal source.
      src[SLOT_DBL] = DBL_INT;
   end

   // ==========================================================
   // Hard-wired system event map
   always_comb begin
      // fixed event numbers. Unlisted numbers read as constant zero.
      evt = '0;
      evt[EVT_COMB +: N_CMB] = cmb;
      evt[EVT_A2D +: N_A2D] = dbl_stat[N_A2D-1:0];
      // signal-side copy. All 54 peripheral lines also reach the signal processor.
      evt[EVT_PERIPH +: N_PERIPH] = PERIPH_IRQ;
      evt[EVT_GPIO +: N_GPIO] = pin_evt;
      evt[EVT_GPIO_GRP] = grp_evt;
      // Combiners must not see their own outputs, or a set mask bit would latch forever.
      evt_nc = evt;
      evt_nc[EVT_COMB +: N_CMB] = '0;
   end

   // ==========================================================
   // Arbitration
   always_comb begin
      for (int i = 0; i < N_SLOT; i++) begin
         steer_fiq[i] = cfg[i*CFG_W + CFG_FIQ_BIT];
      end
      // per-slot enable. Disabled slots stay pending but never compete.
      req_irq = pend & en & ~steer_fiq;
      // steering split. Each slot competes on exactly one of the two lines.
      req_fiq = pend & en & steer_fiq;
   end

   dci_prio_arb u_arb_irq (
      .req(req_irq),
      .cfg(cfg),
      .win(irq_win)
   );

   dci_prio_arb u_arb_fiq (
      .req(req_fiq),
      .cfg(cfg),
      .win(fiq_win)
   );

   // ==========================================================
   // Register writes, pending latch and doorbells
   always_comb begin
      next_en = en;
      next_cfg = cfg;
      next_sel = sel;
      next_cmb_mask = cmb_mask;
      next_exc_mask = exc_mask;
      next_dmask = dmask;
      next_dctl = dctl;
      next_pol = pol;
      next_dbl_en = dbl_en;
      next_pend = pend;
      dbl_set = '0;
      dbl_clr = '0;
      dbl_set[DBL_D2A] = DSP_RING;
      if (WR) begin
         case (ADDR)
            ADR_EN_LO: next_en[31:0] = WDATA;
            ADR_EN_HI: next_en[63:32] = WDATA;
            ADR_PEND_LO: next_pend[31:0] = pend[31:0] & ~WDATA;
            ADR_PEND_HI: next_pend[63:32] = pend[63:32] & ~WDATA;
            ADR_DMASK: next_dmask = WDATA[N_SEL-1:0];
            ADR_DCTL: next_dctl = WDATA[0];
            ADR_POL_LO: next_pol[31:0] = WDATA;
            ADR_POL_HI: next_pol[N_GPIO-1:32] = WDATA[N_GPIO-33:0];
            ADR_DBL_CLR: dbl_clr = WDATA[N_DBL-1:0];
            ADR_DBL_EN: next_dbl_en = WDATA[N_DBL-1:0];
            ADR_DBL_RING: dbl_set[N_A2D-1:0] = WDATA[N_A2D-1:0];
            default: ;
         endcase
         for (int k = 0; k < N_SLOT*CFG_W/32; k++) begin
            if (ADDR == ADR_CFG0 + 8'(4*k)) next_cfg[32*k +: 32] = WDATA;
         end
         for (int k = 0; k < N_SEL/4; k++) begin
            for (int b = 0; b < 4; b++) begin
               if (ADDR == ADR_SEL0 + 8'(4*k)) next_sel[4*k+b] = WDATA[SEL_FIELD_W*b +: EVT_W];
            end
         end
         for (int k = 0; k < N_CMB; k++) begin
            if (ADDR == ADR_CMB0 + 8'(4*k)) next_cmb_mask[k] = WDATA;
            if (ADDR == ADR_EXC0 + 8'(4*k)) next_exc_mask[32*k +: 32] = WDATA;
         end
      end
      // pending latch. A source event set in the clear cycle wins.
      next_pend = next_pend | src;
      // doorbell status. Ring wins over a same-cycle clear.
      next_dbl_stat = dbl_stat & ~dbl_clr | dbl_set;
      next_dbl_int = |(next_dbl_stat & next_dbl_en);
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         en <= '0;
         cfg <= '0;
         sel <= '0;
         cmb_mask <= '0;
         exc_mask <= '0;
         dmask <= '0;
         dctl <= RST_DCTL;
         pol <= '0;
         dbl_en <= RST_DBL_EN;
         dbl_stat <= '0;
         pend <= '0;
         DBL_INT <= 1'b0;
      end else begin
         en <= next_en;
         cfg <= next_cfg;
         sel <= next_sel;
         cmb_mask <= next_cmb_mask;
         exc_mask <= next_exc_mask;
         dmask <= next_dmask;
         dctl <= next_dctl;
         pol <= next_pol;
         dbl_en <= next_dbl_en;
         dbl_stat <= next_dbl_stat;
         pend <= next_pend;
         DBL_INT <= next_dbl_int;
      end
   end

   // ==========================================================
   // Signal-processor lines
   always_comb begin
      for (int k = 0; k < N_CMB; k++) begin
         next_cmb[k] = |(evt_nc[32*k +: 32] & cmb_mask[k]);
      end
      // fixed lines. Reset follows the control bit, NMI the pin, exception its combiner.
      next_line[LINE_RST] = dctl;
      next_line[LINE_NMI] = nmi_s2;
      next_line[LINE_EXC] = |(evt_nc & exc_mask);
      // event selector. Each line picks one event number and has its own mask.
      for (int c = 0; c < N_SEL; c++) begin
         next_line[LINE_SEL + c] = evt[sel[c]] & dmask[c];
      end
   end

   // The NMI pin passes two flip-flops; only nmi_s2 reads nmi_s1.
   // fifteen lines. Three fixed plus twelve selectable, all registered.
   // two request lines. IRQ and FIQ each come straight from a flip-flop.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         cmb <= '0;
         nmi_s1 <= 1'b0;
         nmi_s2 <= 1'b0;
         DSP_INT <= '0;
         ARM_IRQ <= 1'b0;
         ARM_IRQ_NUM <= '0;
         ARM_FIQ <= 1'b0;
         ARM_FIQ_NUM <= '0;
      end else begin
         cmb <= next_cmb;
         nmi_s1 <= NMI_PIN;
         nmi_s2 <= nmi_s1;
         DSP_INT <= next_line;
         ARM_IRQ <= irq_win.valid;
         ARM_IRQ_NUM <= irq_win.idx;
         ARM_FIQ <= fiq_win.valid;
         ARM_FIQ_NUM <= fiq_win.idx;
      end
   end

   // ==========================================================
   // Read port; data stand only in the cycle after the strobe.
   always_comb begin
      next_rdata = '0;
      if (RD) begin
         case (ADDR)
            ADR_EN_LO: next_rdata = en[31:0];
            ADR_EN_HI: next_rdata = en[63:32];
            ADR_STAT: next_rdata = {17'h0_0000, fiq_win, 1'b0, irq_win};
            ADR_PEND_LO: next_rdata = pend[31:0];
            ADR_PEND_HI: next_rdata = pend[63:32];
            ADR_DMASK: next_rdata = 32'(dmask);
            ADR_DLINE: next_rdata = 32'(DSP_INT);
            ADR_DCTL: next_rdata = 32'(dctl);
            ADR_POL_LO: next_rdata = pol[31:0];
            ADR_POL_HI: next_rdata = 32'(pol[N_GPIO-1:32]);
            ADR_DBL_STAT: next_rdata = 32'(dbl_stat);
            ADR_DBL_EN: next_rdata = 32'(dbl_en);
            default: ;
         endcase
         for (int k = 0; k < N_SLOT*CFG_W/32; k++) begin
            if (ADDR == ADR_CFG0 + 8'(4*k)) next_rdata = cfg[32*k +: 32];
         end
         for (int k = 0; k < N_SEL/4; k++) begin
            for (int b = 0; b < 4; b++) begin
               if (ADDR == ADR_SEL0 + 8'(4*k)) next_rdata[SEL_FIELD_W*b +: EVT_W] = sel[4*k+b];
            end
         end
         for (int k = 0; k < N_CMB; k++) begin
            if (ADDR == ADR_CMB0 + 8'(4*k)) next_rdata = cmb_mask[k];
            if (ADDR == ADR_EXC0 + 8'(4*k)) next_rdata = exc_mask[32*k +: 32];
         end
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         RDATA <= '0;
      end else begin
         RDATA <= next_rdata;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   a_irq_win_out: assert property (irq_win.valid |=> ARM_IRQ && ARM_IRQ_NUM == $past(irq_win.idx))
      else $error("IRQ winner not presented");
   a_fiq_win_out: assert property (!fiq_win.valid |=> !ARM_FIQ)
      else $error("FIQ raised without a winner");
   a_irq_enabled: assert property (ARM_IRQ |-> (($past(en) >> ARM_IRQ_NUM) & 64'h0000_0000_0000_0001) != 0)
      else $error("IRQ from a disabled slot");
   a_steer_split: assert property (irq_win.valid && fiq_win.valid |-> irq_win.idx != fiq_win.idx)
      else $error("one slot on both lines");
   a_spare_slots: assert property (pend[N_SLOT-1:N_ACTIVE] == '0)
      else $error("spare slot pending");
   a_sel_line: assert property (evt[sel[0]] && dmask[0] |=> DSP_INT[LINE_SEL])
      else $error("selected event not on line");
   a_sel_masked: assert property (!dmask[0] |=> !DSP_INT[LINE_SEL])
      else $error("masked line raised");
   a_dsp_reset: assert property ($past(NRST) |=> DSP_INT[LINE_RST] == $past(dctl))
      else $error("reset line not following control");
   a_ring_wins: assert property (dbl_set[0] |=> dbl_stat[0])
      else $error("doorbell lost or not routed");
   a_grp_pending: assert property (grp_evt |=> pend[SLOT_GPIO_GRP])
      else $error("pin group event not pending");
   a_read_window: assert property (!RD |=> RDATA == 32'h0000_0000)
      else $error("read data outside its cycle");

   c_irq_taken: cover property (ARM_IRQ ##1 ARM_FIQ);
   c_both_lines: cover property (ARM_IRQ && ARM_FIQ);
   c_dsp_sel: cover property (DSP_INT[LINE_SEL] && DSP_INT[LINE_EXC]);
   c_doorbell: cover property (DBL_INT && DSP_INT[LINE_SEL]);
endmodule // dci_top

// File: bench/dci_core_model.sv
/*
 * Partner model of both cores: the control core fetches a handler per request, the signal core rings.
 * Assumes the router's clock and active-low reset.
 */
`timescale 1ns/1ps
module dci_core_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic irq,
   input wire logic [5:0] irq_num,
   input wire logic fiq,
   input wire logic [5:0] fiq_num,
   input wire logic ring_req,
   output logic ring,
   output logic [31:0] handler
);
   // ==========================================================
   // Entry table
   logic [31:0] vec_tab [64];
   // table filled first
   // Filled at time zero so no request can ever find an empty entry.
   initial begin
      for (int i = 0; i < 64; i++) begin
         vec_tab[i] = 32'h0000_1000 + 32'(4 * i);
      end
   end
   // ==========================================================
   // Requests
   // handler from table
   // A fast request is taken before a normal one, as a core would.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         handler <= '0;
      end else if (fiq) begin
         handler <= vec_tab[fiq_num];
      end else if (irq) begin
         handler <= vec_tab[irq_num];
      end
   end
   // signal core rings
   // The bench asks for a one-cycle ring, so the pulse stays one cycle long.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ring <= 1'b0;
      end else begin
         ring <= ring_req;
      end
   end
endmodule // dci_core_model

// File: bench/tb_top.sv
/*
 * Self-checking bench for the interrupt router, with a slot model built from integers.
 * Assumes dci_pkg and the core model are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
   import dci_pkg::*;
   logic CLK, NRST, WR, RD, NMI_PIN, DSP_RING, ARM_IRQ, ARM_FIQ, DBL_INT, ring_req;
   logic [7:0] ADDR;
   logic [31:0] WDATA, RDATA, handler, rv;
   logic [N_PERIPH-1:0] PERIPH_IRQ;
   logic [N_GPIO-1:0] GPIO_PIN;
   logic [5:0] ARM_IRQ_NUM, ARM_FIQ_NUM;
   logic [N_LINE-1:0] DSP_INT;
   logic [63:0] en, pend;
   logic [31:0] cfgw [8];
   logic [31:0] selw [3];
   int lvl [64];
   bit fq [64];
   int fails, samples_checked, a, b, r, wi, wf;
   int seed = 32'h42f8;
   // ==========================================================
   // Clock, design and partner
   // Free-running 40 MHz clock.
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   dci_top i_dut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .PERIPH_IRQ(PERIPH_IRQ), .GPIO_PIN(GPIO_PIN), .NMI_PIN(NMI_PIN), .DSP_RING(DSP_RING),
      .ARM_IRQ(ARM_IRQ), .ARM_IRQ_NUM(ARM_IRQ_NUM), .ARM_FIQ(ARM_FIQ), .ARM_FIQ_NUM(ARM_FIQ_NUM),
      .DSP_INT(DSP_INT), .DBL_INT(DBL_INT));
   dci_core_model i_core (.clk(CLK), .nrst(NRST), .irq(ARM_IRQ), .irq_num(ARM_IRQ_NUM), .fiq(ARM_FIQ),
      .fiq_num(ARM_FIQ_NUM), .ring_req(ring_req), .ring(DSP_RING), .handler(handler));
   // ==========================================================
   // Tasks
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge CLK);
      ADDR <= ad;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   // Read data is taken in the single cycle after the strobe.
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge CLK);
      ADDR <= ad;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask
   task automatic chk_rd(input string nm, input logic [7:0] ad, input logic [31:0] e);
      rd(ad, rv);
      chk(nm, e, rv);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic set_en(input logic [63:0] e);
      en = e;
      wr(ADR_EN_LO, e[31:0]);
      wr(ADR_EN_HI, e[63:32]);
   endtask
   task automatic set_cfg(input int i, input int v);
      lvl[i] = v & 7;
      fq[i] = v[3];
      cfgw[i/8][4*(i%8) +: 4] = 4'(v);
      wr(ADR_CFG0 + 8'(4 * (i / 8)), cfgw[i/8]);
   endtask
   task automatic clr_pend();
      pend = '0;
      wr(ADR_PEND_LO, 32'hFFFF_FFFF);
      wr(ADR_PEND_HI, 32'hFFFF_FFFF);
   endtask
   task automatic pulse(input logic [N_PERIPH-1:0] m);
      @(posedge CLK) PERIPH_IRQ <= m;
      @(posedge CLK) PERIPH_IRQ <= '0;
      pend[N_PERIPH-1:0] |= m;
   endtask
   // Level 0 is most urgent; the ascending scan leaves ties with the lowest slot.
   function automatic int win(input bit f);
      int w = -1;
      for (int i = 0; i < 64; i++) begin
         if (en[i] && pend[i] && fq[i] == f && (w < 0 || lvl[i] < lvl[w])) w = i;
      end
      return w;
   endfunction
   // Index fields of the status word are compared only while their valid bit is set.
   task automatic chk_arm();
      logic [31:0] e;
      e = '0;
      wi = win(1'b0);
      wf = win(1'b1);
      if (wi >= 0) e[6:0] = {1'b1, 6'(wi)};
      if (wf >= 0) e[14:8] = {1'b1, 6'(wf)};
      chk("irq", 32'(e[6]), 32'(ARM_IRQ));
      chk("fiq", 32'(e[14]), 32'(ARM_FIQ));
      if (wi >= 0) chk("irq_num", 32'(wi), 32'(ARM_IRQ_NUM));
      if (wf >= 0) chk("fiq_num", 32'(wf), 32'(ARM_FIQ_NUM));
      if (e[6] || e[14]) chk("handler", 32'h0000_1000 + 32'(4 * (e[14] ? wf : wi)), handler);
      rd(ADR_STAT, rv);
      chk("status", e, rv & {17'h0, 1'b1, {6{e[14]}}, 2'b11, {6{e[6]}}});
   endtask
   // ==========================================================
   // Watchdog
   // Whole run is near 800 cycles; this margin only trips on a hang.
   initial begin
      repeat (20000) @(posedge CLK);
      fails++;
      stop_test();
   end
   // ==========================================================
   // Main sequence
   initial begin
      {ADDR, WDATA, WR, RD, PERIPH_IRQ, GPIO_PIN, NMI_PIN, ring_req, NRST} = '0;
      en = '0;
      pend = '0;
      foreach (cfgw[k]) cfgw[k] = '0;
      foreach (selw[k]) selw[k] = '0;
      repeat (6) @(posedge CLK);
      #1 chk("rst_out", 0, 32'({ARM_IRQ, ARM_FIQ, DBL_INT, DSP_INT}));
      @(posedge CLK) NRST <= 1'b1;
      wt(2);
      chk("dsp_rst", 32'h0000_0001, 32'(DSP_INT));
      chk_rd("dctl", ADR_DCTL, 32'h0000_0001);
      chk_rd("dbl_en", ADR_DBL_EN, 32'h0000_0000);
      wr(8'hFC, 32'hFFFF_FFFF);
      chk_rd("unmapped", 8'hFC, 32'h0000_0000);
      chk_rd("wo_clr", ADR_DBL_CLR, 32'h0000_0000);
      wr(ADR_DCTL, 32'h0000_0000);
      wt(2);
      chk("dsp_rst_off", 0, 32'(DSP_INT));
      set_en('1);
      pulse('1);
      wt(3);
      chk_rd("pend_lo", ADR_PEND_LO, 32'hFFFF_FFFF);
      chk_rd("pend_hi", ADR_PEND_HI, 32'h003F_FFFF);
      chk_arm();
      clr_pend();
      wt(3);
      chk_arm();
      // masking, steering and levels over random pairs
      for (int t = 0; t < 12; t++) begin
         a = $unsigned($random(seed)) % N_PERIPH;
         b = (a + 1 + $unsigned($random(seed)) % (N_PERIPH - 1)) % N_PERIPH;
         r = $random(seed);
         set_cfg(a, r);
         set_cfg(b, t < 3 ? r : $random(seed));
         set_en(64'(1) << a);
         pulse((N_PERIPH'(1) << a) | (N_PERIPH'(1) << b));
         wt(3);
         chk_arm();
         set_en((64'(1) << a) | (64'(1) << b));
         wt(3);
         chk_rd("pend", ADR_PEND_LO, pend[31:0]);
         chk_arm();
         clr_pend();
         wt(3);
         chk_arm();
      end
      set_en(64'h0440_0000_0000_0000);
      for (int p = 0; p < 2; p++) begin
         wr(ADR_POL_LO, 32'(p));
         for (int k = 0; k < 2; k++) begin
            clr_pend();
            @(posedge CLK) GPIO_PIN[0] <= ~GPIO_PIN[0];
            wt(8);
            if (GPIO_PIN[0] != p[0]) pend |= 64'h0440_0000_0000_0000;
            chk_rd("pin_pend", ADR_PEND_HI, pend[63:32]);
            chk_arm();
         end
      end
      clr_pend();
      for (int c = 0; c < N_SEL; c++) begin
         a = $unsigned($random(seed)) % N_PERIPH;
         selw[c/4][8*(c%4) +: 8] = 8'(EVT_PERIPH + a);
         wr(ADR_SEL0 + 8'(4 * (c / 4)), selw[c/4]);
         wr(ADR_DMASK, 32'(1) << c);
         @(posedge CLK) PERIPH_IRQ[a] <= 1'b1;
         wt(3);
         chk("dsp_sel", 32'(1) << (c + LINE_SEL), 32'(DSP_INT));
         chk_rd("dline", ADR_DLINE, 32'(1) << (c + LINE_SEL));
         @(posedge CLK) PERIPH_IRQ[a] <= 1'b0;
         wt(3);
         chk("dsp_off", 0, 32'(DSP_INT));
      end
      a = $unsigned($random(seed)) % 32;
      wr(ADR_CMB0 + 8'h04, 32'(1) << a);
      wr(ADR_EXC0 + 8'h04, 32'(1) << a);
      selw[0][7:0] = 8'(EVT_COMB + 1);
      wr(ADR_SEL0, selw[0]);
      wr(ADR_DMASK, 32'h0000_0001);
      @(posedge CLK) PERIPH_IRQ[a] <= 1'b1;
      NMI_PIN <= 1'b1;
      wt(5);
      chk("dsp_cmb", 32'h0000_000E, 32'(DSP_INT));
      @(posedge CLK) PERIPH_IRQ[a] <= 1'b0;
      NMI_PIN <= 1'b0;
      wt(5);
      chk("dsp_cmb_off", 0, 32'(DSP_INT));
      clr_pend();
      set_en(64'(1) << SLOT_DBL);
      wr(ADR_DBL_EN, 32'h0000_0010);
      wr(ADR_DBL_RING, 32'h0000_0005);
      selw[0][7:0] = 8'(EVT_A2D);
      wr(ADR_SEL0, selw[0]);
      wt(2);
      chk_rd("dbl_stat", ADR_DBL_STAT, 32'h0000_0005);
      chk("dbl_masked", 0, 32'(DBL_INT));
      chk("dsp_ring", 32'h0000_0008, 32'(DSP_INT));
      @(posedge CLK) ring_req <= 1'b1;
      @(posedge CLK) ring_req <= 1'b0;
      wt(6);
      chk("dbl_int", 1, 32'(DBL_INT));
      chk_rd("dbl_stat2", ADR_DBL_STAT, 32'h0000_0015);
      pend[SLOT_DBL] = 1'b1;
      chk_arm();
      wr(ADR_DBL_CLR, 32'h0000_001F);
      clr_pend();
      wt(3);
      chk_rd("dbl_clr", ADR_DBL_STAT, 32'h0000_0000);
      chk("dbl_off", 0, 32'({DBL_INT, DSP_INT}));
      chk_arm();
      stop_test();
   end
endmodule // tb_top
